/* File: verilog/fanlo_top.sv */
// How it works
// - ramp off and loop off: a written drive value reaches the pwm at once.
// - ramp on and loop off: drive steps toward setting, at most fan step per update.
// - tach passes a glitch filter unless the bypass bit 5 is set.
// - derivative_select at bits 4:3, reset 11, acts only in the speed loop.
// - option 00: no derivative term, steps limited to fan step.
// - option 01: derivative added to the p term, steps limited.
// - option 10: derivative added, fan step limit ignored.
// - option 11: derivative counted twice, fan step limit ignored.
// - error window 0/50/100/200 rpm, bits 2:1; inside it drive holds.
// - polarity clear: 00h gives 0% duty, ffh gives 100% duty.
// - polarity set: 00h gives 100% duty, ffh gives 0% duty.
// - polarity only flips the pin, stored drive values keep meaning.
// - update period 100..1600 ms by three bits, reset 400 ms.
// - fan step is the largest drive change per update when limited.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module fanlo_top
	import fanlo_pkg::*;
#(
	parameter int MS_CYCLES = TICK_CYCLES
)(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// fan
	input wire logic tach_in,
	output logic pwm_out
);
	logic rst_meta, rst_n;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	function automatic logic signed [17:0] lim(
		input logic signed [17:0] d,
		input logic signed [17:0] s
	);
		lim = (d > s) ? s : ((d < -s) ? -s : d);
	endfunction

	function automatic logic [7:0] sat(input logic signed [17:0] v);
		sat = (v < 18'sd0) ? 8'h00 : ((v > 18'sd255) ? 8'hff : v[7:0]);
	endfunction

	// ---- bus slave ----
	logic wr_pend, rd_pend, dp_map;
	logic [7:0] dp_idx;
	logic [3:0] control;
	logic [7:0] drive_setting, fan_step, fan_loop_options, drive;
	logic [15:0] target_speed, measured_speed;
	// hsize is not checked: every register is one aligned word
	wire addr_ok = hsel && htrans[1] && hready;
	wire in_map = (haddr[31:10] == 22'h000000);
	// reads take one wait state so a write just before is seen
	wire next_hreadyout = !(addr_ok && !hwrite);
	wire wr_en = wr_pend && dp_map;
	wire wr_ctl = wr_en && dp_idx == IDX_CONTROL;
	wire wr_drv = wr_en && dp_idx == IDX_DRIVE;
	wire wr_stp = wr_en && dp_idx == IDX_STEP;
	wire wr_opt = wr_en && dp_idx == IDX_OPTIONS;
	wire wr_tgt = wr_en && dp_idx == IDX_TARGET;
	wire [31:0] rd_word =
		!dp_map ? 32'h00000000 :
		(dp_idx == IDX_CONTROL) ? {28'h0000000, control} :
		(dp_idx == IDX_DRIVE) ? {24'h000000, drive_setting} :
		(dp_idx == IDX_STEP) ? {24'h000000, fan_step} :
		(dp_idx == IDX_OPTIONS) ? {24'h000000, fan_loop_options} :
		(dp_idx == IDX_TARGET) ? {16'h0000, target_speed} :
		(dp_idx == IDX_STATUS) ? {24'h000000, drive} :
		(dp_idx == IDX_SPEED) ? {16'h0000, measured_speed} :
		32'h00000000;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			dp_map <= 1'b0;
			dp_idx <= 8'h00;
		end else begin
			wr_pend <= addr_ok && hwrite;
			rd_pend <= addr_ok && !hwrite;
			dp_map <= addr_ok ? in_map : dp_map;
			dp_idx <= addr_ok ? haddr[9:2] : dp_idx;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
		end else begin
			hreadyout <= next_hreadyout;
			hresp <= 1'b0;
			hrdata <= rd_pend ? rd_word : hrdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			control <= CTL_RESET;
			drive_setting <= DRIVE_RESET;
			fan_step <= STEP_RESET;
			fan_loop_options <= OPT_RESET;
			target_speed <= TARGET_RESET;
		end else begin
			if (wr_ctl)
				control <= hwdata[3:0];
			if (wr_drv)
				drive_setting <= hwdata[7:0];
			if (wr_stp)
				fan_step <= hwdata[7:0];
			if (wr_opt)
				fan_loop_options <= hwdata[7:0];
			if (wr_tgt)
				target_speed <= hwdata[15:0];
		end
	end

	// field views
	wire speed_loop = control[CTL_LOOP];
	wire [2:0] upd_sel = control[CTL_UPD_LO +: 3];
	wire manual_ramp_enable = fan_loop_options[OPT_RAMP];
	wire tach_filter_bypass = fan_loop_options[OPT_FILT_BYP];
	wire [1:0] der_bits = fan_loop_options[OPT_DER_LO +: 2];
	wire [1:0] error_window_select = fan_loop_options[OPT_WIN_LO +: 2];
	wire polarity = fan_loop_options[OPT_POLARITY];
	fanlo_der_t derivative_select;
	assign derivative_select = fanlo_der_t'(der_bits);

	// ---- tach input ----
	logic tach_s1, tach_s2, tach_filt, tach_prev;
	logic [FILT_LEN-1:0] tach_hist;
	wire [FILT_LEN-1:0] next_hist = {tach_hist[FILT_LEN-2:0], tach_s2};
	// a level must hold four samples before the filter follows it
	wire all_high = &tach_hist;
	wire all_low = ~|tach_hist;
	wire next_filt = all_high ? 1'b1 : (all_low ? 1'b0 : tach_filt);
	wire tach_clean = tach_filter_bypass ? tach_s2 : tach_filt;
	wire tach_edge = tach_clean && !tach_prev;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// the pin idles high; a low reset would count a false edge
			tach_s1 <= 1'b1;
			tach_s2 <= 1'b1;
			tach_hist <= '1;
			tach_filt <= 1'b1;
			tach_prev <= 1'b1;
		end else begin
			tach_s1 <= tach_in;
			tach_s2 <= tach_s1;
			tach_hist <= next_hist;
			tach_filt <= next_filt;
			tach_prev <= tach_clean;
		end
	end

	// ---- time base ----
	logic [13:0] ms_cnt;
	logic [10:0] upd_cnt;
	logic [9:0] gate_cnt;
	logic [8:0] edge_cnt;
	wire ms_tick = (ms_cnt == 14'(MS_CYCLES - 1));
	wire [10:0] upd_len = fanlo_upd_ms(upd_sel);
	// >= so a shorter period written mid-count ends at the next ms tick
	wire upd_tick = ms_tick && (upd_cnt >= upd_len - 11'h001);
	wire gate_end = ms_tick && (gate_cnt == 10'(GATE_MS - 1));
	wire [8:0] next_edges = (tach_edge && edge_cnt != 9'h1ff) ?
		edge_cnt + 9'h001 : edge_cnt;
	wire [15:0] next_speed = 16'({7'h00, edge_cnt} * RPM_PER_EDGE);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt <= 14'h0000;
			upd_cnt <= 11'h000;
			gate_cnt <= 10'h000;
		end else begin
			ms_cnt <= ms_tick ? 14'h0000 : ms_cnt + 14'h0001;
			if (upd_tick)
				upd_cnt <= 11'h000;
			else if (ms_tick)
				upd_cnt <= upd_cnt + 11'h001;
			if (gate_end)
				gate_cnt <= 10'h000;
			else if (ms_tick)
				gate_cnt <= gate_cnt + 10'h001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_cnt <= 9'h000;
			measured_speed <= 16'h0000;
		end else begin
			edge_cnt <= gate_end ? {8'h00, tach_edge} : next_edges;
			measured_speed <= gate_end ? next_speed : measured_speed;
		end
	end

	// ---- drive calculation ----
	logic signed [17:0] prev_err;
	wire signed [17:0] drive_s = $signed({10'h000, drive});
	wire signed [17:0] step_s = $signed({10'h000, fan_step});
	wire signed [17:0] man_diff = $signed({10'h000, drive_setting}) - drive_s;
	// never overshoots the setting, the step taken is never above the distance
	wire [7:0] man_next = sat(drive_s + lim(man_diff, step_s));
	wire signed [17:0] err = $signed({2'h0, target_speed}) -
		$signed({2'h0, measured_speed});
	wire [15:0] abs_err = err[17] ? 16'(-err) : err[15:0];
	wire in_window = abs_err <= fanlo_win_rpm(error_window_select);
	// fixed gain of 1/32 stands in for the gain register
	wire signed [17:0] p_term = err >>> 5;
	wire signed [17:0] d_raw = (err - prev_err) >>> 5;
	wire signed [17:0] d_term =
		(derivative_select == DER_NONE) ? 18'sd0 :
		(derivative_select == DER_BOTH) ? d_raw <<< 1 :
		d_raw;
	wire signed [17:0] raw_delta = p_term + d_term;
	wire step_free = der_bits[1];
	wire signed [17:0] loop_delta = step_free ? raw_delta :
		lim(raw_delta, step_s);
	wire [7:0] loop_next = in_window ? drive :
		sat(drive_s + loop_delta);
	wire [7:0] man_drive = manual_ramp_enable ?
		(upd_tick ? man_next : drive) :
		drive_setting;
	wire [7:0] next_drive = speed_loop ?
		(upd_tick ? loop_next : drive) : man_drive;
	wire signed [17:0] next_prev_err = (speed_loop && upd_tick) ?
		err : prev_err;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive <= DRIVE_RESET;
			prev_err <= 18'sd0;
		end else begin
			drive <= next_drive;
			prev_err <= next_prev_err;
		end
	end

	// polarity reaches only the pin stage; drive keeps its meaning
	fanlo_pwm u_pwm (
		.clk(clk),
		.rst_n(rst_n),
		.duty(drive),
		.invert(polarity),
		.pwm_out(pwm_out)
	);

	// ---- checks ----
	immediate_drive_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		(!speed_loop && !manual_ramp_enable) |=>
		drive == $past(drive_setting))
		else $error("manual drive not applied at once");
	ramp_hold_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		(!speed_loop && manual_ramp_enable && !upd_tick) |=>
		$stable(drive))
		else $error("ramp moved between updates");
	ramp_step_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		(!speed_loop && manual_ramp_enable && upd_tick) |=>
		((drive >= $past(drive)) ? (drive - $past(drive)) :
		($past(drive) - drive)) <= $past(fan_step))
		else $error("ramp step above fan step");
	filter_hold_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		(!tach_filter_bypass && !all_high && !all_low) |=>
		tach_filt == $past(tach_filt))
		else $error("filter followed a glitch");
	window_hold_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		(speed_loop && upd_tick && in_window) |=> $stable(drive))
		else $error("drive changed inside error window");
	loop_limit_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		(speed_loop && upd_tick && !der_bits[1]) |=>
		((drive >= $past(drive)) ? (drive - $past(drive)) :
		($past(drive) - drive)) <= $past(fan_step))
		else $error("loop step above fan step");
	loop_idle_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		(speed_loop && !upd_tick) |=> $stable(drive))
		else $error("loop drive moved off update");
	reset_value_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		$rose(rst_n) |-> fan_loop_options == OPT_RESET &&
		control == CTL_RESET)
		else $error("options not at reset value");
	readback_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		(rd_pend && dp_map && dp_idx == IDX_OPTIONS) |=>
		hreadyout && hrdata == {24'h000000, $past(fan_loop_options)})
		else $error("options readback wrong");
	write_land_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		(wr_pend && dp_map && dp_idx == IDX_OPTIONS) |=>
		fan_loop_options == $past(hwdata[7:0]))
		else $error("options write lost");
	read_wait_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		(addr_ok && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	bus_okay_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		!hresp)
		else $error("bus response not okay");
	ramp_toward_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		(!speed_loop && manual_ramp_enable && upd_tick &&
		fan_step != 8'h00 && drive != drive_setting) |=>
		(drive != $past(drive)) &&
		((drive > $past(drive)) == ($past(drive_setting) > $past(drive))))
		else $error("ramp moved away from setting");
	loop_off_err_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		!speed_loop |=> $stable(prev_err))
		else $error("derivative history moved off loop");
	upd_range_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		upd_cnt < fanlo_upd_ms(3'h7))
		else $error("update counter out of range");
endmodule
`default_nettype wire

/* File: verilog/fanlo_pkg.sv */
`default_nettype none
package fanlo_pkg;
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int GATE_MS = 600;
	localparam int FILT_LEN = 4;
	// two tach pulses per turn counted over the 600 ms gate
	localparam logic [15:0] RPM_PER_EDGE = 16'h0032;
	localparam logic [7:0] PWM_TOP = 8'hfe;
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_CONTROL = 8'h00;
	localparam logic [7:0] IDX_DRIVE = 8'h01;
	localparam logic [7:0] IDX_STEP = 8'h02;
	localparam logic [7:0] IDX_OPTIONS = 8'h03;
	localparam logic [7:0] IDX_TARGET = 8'h04;
	localparam logic [7:0] IDX_STATUS = 8'h05;
	localparam logic [7:0] IDX_SPEED = 8'h06;
	// fan_loop_options fields
	localparam int OPT_POLARITY = 0;
	localparam int OPT_WIN_LO = 1;
	localparam int OPT_DER_LO = 3;
	localparam int OPT_FILT_BYP = 5;
	localparam int OPT_RAMP = 6;
	localparam logic [7:0] OPT_RESET = 8'h1a;
	// control fields
	localparam int CTL_LOOP = 0;
	localparam int CTL_UPD_LO = 1;
	localparam logic [3:0] CTL_RESET = 4'h6;
	localparam logic [7:0] DRIVE_RESET = 8'h00;
	localparam logic [7:0] STEP_RESET = 8'h10;
	localparam logic [15:0] TARGET_RESET = 16'h0000;

	typedef enum logic [1:0] {
		DER_NONE,
		DER_BASIC,
		DER_STEP,
		DER_BOTH
	} fanlo_der_t;

	function automatic logic [10:0] fanlo_upd_ms(input logic [2:0] sel);
		case (sel)
			3'h0: fanlo_upd_ms = 11'h064;
			3'h1: fanlo_upd_ms = 11'h0c8;
			3'h2: fanlo_upd_ms = 11'h12c;
			3'h3: fanlo_upd_ms = 11'h190;
			3'h4: fanlo_upd_ms = 11'h1f4;
			3'h5: fanlo_upd_ms = 11'h320;
			3'h6: fanlo_upd_ms = 11'h4b0;
			default: fanlo_upd_ms = 11'h640;
		endcase
	endfunction

	function automatic logic [15:0] fanlo_win_rpm(input logic [1:0] sel);
		case (sel)
			2'h0: fanlo_win_rpm = 16'h0000;
			2'h1: fanlo_win_rpm = 16'h0032;
			2'h2: fanlo_win_rpm = 16'h0064;
			default: fanlo_win_rpm = 16'h00c8;
		endcase
	endfunction
endpackage
`default_nettype wire

/* File: verilog/fanlo_pwm.sv */
`timescale 1ns/1ps
`default_nettype none
module fanlo_pwm
	import fanlo_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// drive
	input wire logic [7:0] duty,
	input wire logic invert,
	// pin
	output logic pwm_out
);
	logic [7:0] cnt;
	// 255 slots per period so that ff is high in every slot
	wire [7:0] next_cnt = (cnt == PWM_TOP) ? 8'h00 : cnt + 8'h01;
	wire next_pwm = (cnt < duty) ^ invert;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 8'h00;
			pwm_out <= 1'b0;
		end else begin
			cnt <= next_cnt;
			pwm_out <= next_pwm;
		end
	end

	normal_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		($past(duty) == 8'h00 && !$past(invert)) |-> !pwm_out)
		else $error("normal zero drive not low");
	normal_full_a: assert property (@(posedge clk) disable iff (!rst_n)
		($past(duty) == 8'hff && !$past(invert)) |-> pwm_out)
		else $error("normal full drive not high");
	inverted_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		($past(invert) && ($past(duty) == 8'h00 || $past(duty) == 8'hff))
		|-> pwm_out == ($past(duty) == 8'h00))
		else $error("inverted drive wrong level");
endmodule
`default_nettype wire

/* File: tb/fanlo_fan_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fanlo_fan_model (
	// clock
	input wire logic clk,
	// drive and mode
	input wire logic pwm_in,
	input wire logic [1:0] mode,
	// tach pin, pulled up in modes 0 and 3; held at its level while the fan stands
	output logic tach
);
	logic [4:0] ph = 5'h00;
	// the rotor turns only while the drive pin is high
	always @(posedge clk) begin
		if (pwm_in)
			ph <= (ph == 5'h13) ? 5'h00 : ph + 5'h01;
	end
	// mode 1: two-cycle dips, too short to survive a filter; mode 2: clean
	always_comb begin
		case (mode)
			2'h1: tach = (ph > 5'h01);
			2'h2: tach = (ph > 5'h09);
			default: tach = 1'b1;
		endcase
	end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import fanlo_pkg::*;
;
	localparam int MS = 10;
	typedef struct {
		string name;
		logic [31:0] exp;
		logic [31:0] mask;
	} fanlo_note_t;
	logic clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, tach, pwm, dph;
	logic [31:0] haddr, hwdata, hrdata, rnd, v;
	logic [1:0] htrans, fmode;
	logic [2:0] hsize;
	int bad_count, total_checks, cyc, t0;
	fanlo_note_t notes[$];
	fanlo_note_t nt;
	assign hready = hreadyout;
	fanlo_top #(.MS_CYCLES(MS)) DUT (.clk(clk), .reset_n(reset_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.tach_in(tach), .pwm_out(pwm));
	fanlo_fan_model fan (.clk(clk), .pwm_in(pwm), .mode(fmode), .tach(tach));
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g, input logic [31:0] tol);
		total_checks++;
		if (((g + tol >= e) && (g <= e + tol)) !== 1'b1) begin
			bad_count++;
			$display("unexpected %s: expected %0h, seen %0h", nm, e, g);
		end
	endtask
	task automatic wait_rdy();
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'b1);
	endtask
	task automatic addr_ph(input logic [31:0] a, input logic wr_en);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr_en;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		addr_ph(a, 1'b1);
		hwdata <= d;
		wait_rdy();
	endtask
	// the read data itself is judged by the bus watcher below
	task automatic rd(input logic [31:0] a, input string nm,
		input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{nm, e, m});
		addr_ph(a, 1'b0);
		wait_rdy();
		v = hrdata;
	endtask
	task automatic poll(input logic [31:0] old);
		t0 = cyc;
		do begin
			rd(32'h14, "", 32'h0, 32'h0);
		end while (v === old && cyc - t0 < 2500);
	endtask
	task automatic duty(input logic [31:0] e);
		logic [31:0] h;
		h = 0;
		repeat (4) @(posedge clk);
		repeat (255) begin
			@(posedge clk);
			h = h + pwm;
		end
		cmp("pwm high cycles", e, h, 0);
	endtask
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (dph && hready && notes.size() > 0) begin
			nt = notes.pop_front();
			cmp(nt.name, nt.exp & nt.mask, hrdata & nt.mask, 0);
			cmp("hresp", 0, {31'h0, hresp}, 0);
		end
		if (hready) dph <= hsel && htrans[1] && !hwrite;
		if (cyc == 80000) begin
			bad_count++;
			end_of_test();
		end
	end
	initial begin
		reset_n = 1'b0;
		{hsel, hwrite} = 2'h0;
		{haddr, hwdata} = 64'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		fmode = 2'h0;
		rnd = 32'h22;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(32'h0c, "options reset", 32'h1a, '1);
		rd(32'h00, "control reset", 32'h06, '1);
		rd(32'h08, "step reset", 32'h10, '1);
		repeat (4) begin
			rnd = xs(rnd);
			wr(32'h0c, rnd);
			rd(32'h0c, "options", {24'h0, rnd[7:0]}, '1);
		end
		rd(32'h3fc, "unmapped", 32'h0, '1);
		wr(32'h0c, 32'h1a);
		wr(32'h04, 32'h80);
		rd(32'h14, "drive at once", 32'h80, '1);
		for (int i = 0; i < 4; i++) begin
			wr(32'h00, 32'h0);
			wr(32'h04, 32'h0);
			wr(32'h0c, 32'(i) << 3);
			wr(32'h10, 32'h3e8);
			wr(32'h00, 32'h1);
			poll(32'h0);
			if (i < 2) cmp("limited step", 32'h10, v, 0);
			else cmp("unlimited step", 1, {31'h0, v > 32'h10}, 0);
		end
		// 75 rpm off target: windows 0 and 50 move, 100 and 200 hold
		for (int j = 0; j < 4; j++) begin
			wr(32'h00, 32'h0);
			wr(32'h04, 32'h0);
			wr(32'h0c, 32'(j) << 1);
			wr(32'h10, 32'h4b);
			wr(32'h00, 32'h1);
			repeat (1200) @(posedge clk);
			rd(32'h14, "", 32'h0, 32'h0);
			cmp("held in window", j >= 2, v == 32'h0, 0);
		end
		wr(32'h00, 32'h2);
		wr(32'h04, 32'h0);
		wr(32'h0c, 32'h5a);
		wr(32'h04, 32'h80);
		poll(32'h0);
		cmp("first ramp step", 32'h10, v, 0);
		poll(32'h10);
		cmp("second ramp step", 32'h20, v, 0);
		cmp("update period", 200 * MS, cyc - t0, 5);
		wr(32'h0c, 32'h1a);
		wr(32'h04, 32'h0);
		duty(0);
		wr(32'h04, 32'hff);
		duty(255);
		wr(32'h0c, 32'h1b);
		duty(0);
		wr(32'h04, 32'h0);
		duty(255);
		rd(32'h04, "setting kept", 32'h0, '1);
		rd(32'h14, "drive kept", 32'h0, '1);
		// full drive keeps the model fan turning
		wr(32'h04, 32'hff);
		for (int i = 0; i < 3; i++) begin
			wr(32'h0c, (i == 2) ? 32'h3a : 32'h1a);
			fmode <= (i == 1) ? 2'h2 : 2'h1;
			repeat (13000) @(posedge clk);
			rd(32'h18, "", 32'h0, 32'h0);
			cmp("measured speed", (i == 0) ? 32'h0 : 32'h3a98, v,
				(i == 0) ? 0 : 100);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
